/* ddrc_consts.svh */
`ifndef DDRC_CONSTS_SVH
`define DDRC_CONSTS_SVH

// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define DDRC_FRAME_UI 10
`define DDRC_DQ_LANES 16
`define DDRC_ALL_LANES 18
`define DDRC_MASK_LANE 16
`define DDRC_TREE_BITS 72
`define DDRC_CRC_BITS 8
`define DDRC_CRC_POLY 8'h07

// ------------------------------------------------------------
// organisation codes
// ------------------------------------------------------------
`define DDRC_ORG_X4 2'h0
`define DDRC_ORG_X8 2'h1
`define DDRC_ORG_X16 2'h2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DDRC_CLK_MHZ 20
`define DDRC_ALERT_PW_MIN 6
`define DDRC_ALERT_PW_MAX 10
`define DDRC_ALERT_PW_DEF 8
`define DDRC_CRC_ALERT_NS 13
`define DDRC_ALERT_LAT_RAW ((`DDRC_CRC_ALERT_NS * `DDRC_CLK_MHZ) / 1000)
`define DDRC_ALERT_LAT_CYC ((`DDRC_ALERT_LAT_RAW < 1) ? 1 : `DDRC_ALERT_LAT_RAW)

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DDRC_RST_UI_CNT 4'h0
`define DDRC_RST_PW_CNT 4'h0

`endif

/* ddrc_pkg.sv */
`include "ddrc_consts.svh"

package ddrc_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // alert pulse sequencer
    typedef enum logic [1:0] {
        DDRC_IDLE = 2'b00,
        DDRC_PULSE = 2'b01
    } ddrc_alert_st_t;

    // one frame: ten transfers of all lanes
    typedef logic [`DDRC_FRAME_UI-1:0][`DDRC_ALL_LANES-1:0] ddrc_frame_t;

    // whole state of the checker
    typedef struct packed {
        logic [`DDRC_ALL_LANES+1:0] sync1;
        logic [`DDRC_ALL_LANES+1:0] sync2;
        logic [`DDRC_ALL_LANES+1:0] sync3;
        logic strobe_lvl;
        logic active;
        logic [3:0] ui_cnt;
        ddrc_frame_t frame;
        logic done;
        ddrc_alert_st_t st;
        logic [3:0] pw_cnt;
        logic alert_oe;
        logic alert_lvl;
        logic clr_bit;
        logic status_bit;
    } ddrc_state_t;

endpackage : ddrc_pkg

/* ddrc_write_crc_check.sv */
`timescale 1ns/1ns
`include "ddrc_consts.svh"

// How it works
// - x8 bl8: lane n data, crc n, one
// - x16 is two independent x8 checkers
// - x16 upper byte carries bits 72-143
// - crc errors share the one alert line
// - alert low pulse of six to ten cycles
// - alert starts one cycle (50 ns) after detection, not within 13 ns
// - error sets clear bit and status bit
// - clear bit holds until mode register clear
// - device only pulls low, then releases
// - checking enabled by mode bit, bl8 and bc4
// - every frame is exactly ten transfers
// - x4 bc4: 16 data bits, rest ones
// - bc4 with a2 high maps upper nibble low
// - x8 bc4: 36 inputs, transfers 4-7 ones
// - x8 bc4 a2 low: mask feeds 67:64
// - x8 bc4 a2 high: mask feeds 71:68
// - polynomial x8+x2+x+1 over 72 bits
// - compare received with computed, flag mismatch
// - mask off: upper eight tree inputs ones
// - data committed before the check completes
module ddrc_write_crc_check #(
    parameter int PULSE_CYC = `DDRC_ALERT_PW_DEF
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // write link pins
    input wire logic wstrobe_i,
    input wire logic wframe_i,
    input wire logic [`DDRC_DQ_LANES-1:0] dq_i,
    input wire logic [1:0] dmi_i,
    // mode configuration
    input wire logic crc_en_i,
    input wire logic [1:0] org_i,
    input wire logic bc4_i,
    input wire logic a2_i,
    input wire logic dm_en_i,
    input wire logic dbi_en_i,
    input wire logic mrs_clr_i,
    // shared open-drain alert pin
    output logic alert_n_o,
    output logic alert_oe_o,
    // status
    output logic crc_clr_bit_o,
    output logic crc_status_o,
    output logic wr_done_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // the pulse width must sit inside the allowed window
    if (PULSE_CYC < `DDRC_ALERT_PW_MIN || PULSE_CYC > `DDRC_ALERT_PW_MAX) begin : g_bad_pw
        $error("pulse width outside six to ten cycles");
    end

    // the pulse counter is four bits wide
    localparam logic [3:0] PW_LAST = 4'(PULSE_CYC - 1);
    // last transfer index of a frame
    localparam logic [3:0] UI_LAST = 4'(`DDRC_FRAME_UI - 1);
    // alert reaches the pin one flop after detection
    localparam int ALERT_LAT = `DDRC_ALERT_LAT_CYC;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // serial crc, first bit d[71], start value zero
    function automatic logic [7:0] crc72(input logic [71:0] d);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = `DDRC_TREE_BITS - 1; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? `DDRC_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc72

    // assembles the 72 tree inputs of one byte group
    function automatic logic [71:0] tree_word(
        input ddrc_pkg::ddrc_frame_t f,
        input logic up,
        input logic x4,
        input logic bc4,
        input logic a2,
        input logic msk
    );
        logic [71:0] w;
        int lane;
        int mbase;
        w = '1;
        mbase = a2 ? 68 : 64;
        // transfers 8 and 9 never reach the tree
        for (int n = 0; n < 8; n++) begin
            lane = up ? n + 8 : n;
            for (int t = 0; t < 8; t++) begin
                // x4 keeps upper 40 inputs at ones
                // bc4 keeps transfers 4 to 7 at ones
                if (!(x4 && n > 3) && !(bc4 && t > 3)) begin
                    // bc4 with a2 high still lands on the low nibble
                    w[8*n+t] = f[t][lane];
                end
            end
        end
        // mask lane feeds the upper inputs only when enabled
        if (msk && !x4) begin
            for (int t = 0; t < 8; t++) begin
                if (!bc4) begin
                    w[64+t] = f[t][`DDRC_MASK_LANE + (up ? 1 : 0)];
                end else if (t < 4) begin
                    w[mbase+t] = f[t][`DDRC_MASK_LANE + (up ? 1 : 0)];
                end
            end
        end
        return w;
    endfunction : tree_word

    // extracts the checksum the controller sent
    function automatic logic [7:0] rx_crc(
        input ddrc_pkg::ddrc_frame_t f,
        input logic up,
        input logic x4
    );
        logic [7:0] r;
        if (x4) begin
            r = {f[9][3:0], f[8][3:0]};
        end else if (up) begin
            // x16 upper group reads lanes 8 to 15
            r = f[8][15:8];
        end else begin
            r = f[8][7:0];
        end
        return r;
    endfunction : rx_crc

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ddrc_pkg::ddrc_state_t s;  // registered state
    ddrc_pkg::ddrc_state_t next_s;  // next state
    logic strobe_stable;  // strobe agrees in stages two and three
    logic strobe_rise;  // qualified rising edge of the strobe
    logic is_x4;  // x4 organisation
    logic is_x16;  // x16 organisation
    logic mask_on;  // data mask or inversion enabled
    logic [7:0] calc_lo;  // computed checksum, lower group
    logic [7:0] calc_hi;  // computed checksum, upper group
    logic mis_lo;  // lower group mismatch
    logic mis_hi;  // upper group mismatch
    logic crc_err;  // detection event

    // ------------------------------------------------------------
    // decode and compare
    // ------------------------------------------------------------
    // checksum trees run on the stored frame
    always_comb begin
        is_x4 = (org_i == `DDRC_ORG_X4);
        is_x16 = (org_i == `DDRC_ORG_X16);
        mask_on = dm_en_i | dbi_en_i;
        calc_lo = crc72(tree_word(s.frame, 1'b0, is_x4, bc4_i, a2_i, mask_on));
        calc_hi = crc72(tree_word(s.frame, 1'b1, is_x4, bc4_i, a2_i, mask_on));
        // each group is checked on its own
        mis_lo = (calc_lo != rx_crc(s.frame, 1'b0, is_x4));
        mis_hi = is_x16 && (calc_hi != rx_crc(s.frame, 1'b1, is_x4));
        // nothing is compared while checking is off
        crc_err = s.done && crc_en_i && (mis_lo || mis_hi);
        // edge found once stages two and three agree
        strobe_stable = (s.sync2[0] == s.sync3[0]);
        strobe_rise = strobe_stable && s.sync3[0] && !s.strobe_lvl;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // pin synchroniser: bit 0 strobe, bit 1 frame, rest lanes
        // stage one is read only by stage two
        next_s.sync1 = {dmi_i, dq_i, wframe_i, wstrobe_i};
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        next_s.done = 1'b0;
        next_s.alert_lvl = 1'b0;
        // strobe level follows only once stable
        if (strobe_stable) begin
            next_s.strobe_lvl = s.sync3[0];
        end
        // one transfer per strobe rising edge
        if (strobe_rise && (s.active || s.sync3[1])) begin
            next_s.frame[s.active ? s.ui_cnt : `DDRC_RST_UI_CNT] = s.sync3[`DDRC_ALL_LANES+1:2];
            if (!s.active) begin
                next_s.active = 1'b1;
                next_s.ui_cnt = 4'h1;
            end else if (s.ui_cnt == UI_LAST) begin
                // tenth transfer closes the frame
                next_s.active = 1'b0;
                next_s.ui_cnt = `DDRC_RST_UI_CNT;
                next_s.done = 1'b1;
            end else begin
                next_s.ui_cnt = s.ui_cnt + 4'h1;
            end
        end
        // sticky bits: detection wins over the clear command
        if (crc_err) begin
            next_s.clr_bit = 1'b1;
            next_s.status_bit = 1'b1;
        end else if (mrs_clr_i) begin
            // only the mode register command clears them
            next_s.clr_bit = 1'b0;
            next_s.status_bit = 1'b0;
        end
        // alert pulse sequencer
        unique case (s.st)
            ddrc_pkg::DDRC_IDLE: begin
                // pull the shared line low right after detection
                if (crc_err) begin
                    next_s.st = ddrc_pkg::DDRC_PULSE;
                    next_s.alert_oe = 1'b1;
                    next_s.pw_cnt = `DDRC_RST_PW_CNT;
                end
            end
            ddrc_pkg::DDRC_PULSE: begin
                // errors inside a pulse only set the sticky bits
                if (s.pw_cnt == PW_LAST) begin
                    next_s.st = ddrc_pkg::DDRC_IDLE;
                    next_s.alert_oe = 1'b0;
                end else begin
                    next_s.pw_cnt = s.pw_cnt + 4'h1;
                end
            end
            // unused codes fall back to a released line
            default: begin
                next_s.st = ddrc_pkg::DDRC_IDLE;
                next_s.alert_oe = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // every field returns to zero, the line is released
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the driven level is always low; the enable makes the pulse
    assign alert_n_o = s.alert_lvl;
    assign alert_oe_o = s.alert_oe;
    // sticky error bits as the mode registers show them
    assign crc_clr_bit_o = s.clr_bit;
    assign crc_status_o = s.status_bit;
    // frame handed to the array without waiting for the check
    assign wr_done_o = s.done;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    // pulse start and its earliest end
    sequence pulse_start_s;
        $rose(alert_oe_o);
    endsequence
    sequence pulse_min_s;
        alert_oe_o [*6];
    endsequence

    a_pulse_min: assert property (pulse_start_s |-> pulse_min_s)
        else $error("alert pulse shorter than six cycles");
    a_pulse_max: assert property (pulse_start_s |-> ##[6:10] !alert_oe_o)
        else $error("alert pulse longer than ten cycles");
    a_alert_latency: assert property (
        (crc_err && s.st == ddrc_pkg::DDRC_IDLE) |-> ##ALERT_LAT alert_oe_o)
        else $error("alert not driven right after detection");
    a_sticky_set: assert property (crc_err |=> crc_clr_bit_o && crc_status_o)
        else $error("error bits not set on mismatch");
    a_sticky_hold: assert property (crc_clr_bit_o && !mrs_clr_i |=> crc_clr_bit_o)
        else $error("clear bit dropped without command");
    a_off_quiet: assert property (
        (!crc_en_i && !alert_oe_o && s.st == ddrc_pkg::DDRC_IDLE) |=> !alert_oe_o)
        else $error("alert pulse while checking disabled");
    a_off_bits: assert property (!crc_en_i && !crc_clr_bit_o |=> !crc_clr_bit_o)
        else $error("error bit set while checking disabled");
    a_drive_low: assert property (alert_oe_o |-> !alert_n_o)
        else $error("alert driven high");
    a_upper_tree: assert property (
        (s.done && crc_en_i && is_x16 && mis_hi) |=> crc_status_o && crc_clr_bit_o)
        else $error("upper group mismatch not flagged");
    a_frame_len: assert property (wr_done_o |-> $past(s.ui_cnt) == UI_LAST)
        else $error("frame closed before ten transfers");

    // ------------------------------------------------------------
    // assertions: causes, sticky bits and framing
    // ------------------------------------------------------------
    // the line is pulled only in answer to a detected mismatch
    a_alert_cause: assert property ($rose(alert_oe_o) |-> $past(crc_err))
        else $error("alert pulse without a checksum mismatch");
    // sticky bits rise only on detection
    a_sticky_cause: assert property ($rose(crc_status_o) |-> $past(crc_err))
        else $error("status bit set without a mismatch");
    // both sticky bits move together
    a_sticky_pair: assert property (crc_clr_bit_o == crc_status_o)
        else $error("clear bit and status bit disagree");
    // the clear command takes effect when no error competes
    a_clear_done: assert property (
        mrs_clr_i && !crc_err |=> !crc_clr_bit_o && !crc_status_o)
        else $error("error bits not cleared by command");
    // the commit marker is a single-cycle pulse
    a_done_pulse: assert property (wr_done_o |=> !wr_done_o)
        else $error("frame end marker longer than one cycle");
    // a running pulse only counts on, a later error never restarts it
    a_no_restart: assert property (
        s.st == ddrc_pkg::DDRC_PULSE |=> !alert_oe_o || s.pw_cnt == $past(s.pw_cnt) + 4'h1)
        else $error("alert pulse restarted or stalled");
    // outside a pulse the line is always released
    a_idle_quiet: assert property (s.st == ddrc_pkg::DDRC_IDLE |-> !alert_oe_o)
        else $error("alert driven while idle");
    // one strobe edge takes exactly one transfer
    a_strobe_once: assert property (strobe_rise |=> !strobe_rise)
        else $error("strobe edge taken twice");
    // the transfer counter never passes the tenth slot
    a_ui_range: assert property (s.ui_cnt <= UI_LAST)
        else $error("transfer counter beyond frame end");

endmodule : ddrc_write_crc_check

/* ddrc_ctrl_model.sv */
`timescale 1ns/1ns
`include "ddrc_consts.svh"

// ------------------------------------------------------------
// write-side controller model: drives ten-transfer frames
// ------------------------------------------------------------
module ddrc_ctrl_model (
    // link pins toward the checker
    output logic wstrobe_o,
    output logic wframe_o,
    output logic [15:0] dq_o,
    output logic [1:0] dmi_o
);
    // strobe stands still low between frames
    initial begin
        wstrobe_o = 1'h0;
        wframe_o = 1'h0;
        dq_o = 16'h0000;
        dmi_o = 2'h0;
    end

    // one frame, strobe period 400 ns, data set 100 ns before the rise
    task automatic send(input ddrc_pkg::ddrc_frame_t f, input logic hold);
        for (int t = 0; t < `DDRC_FRAME_UI; t++) begin
            {dmi_o, dq_o} = f[t];
            wframe_o = (t == 0);
            #100;
            wstrobe_o = 1'h1;
            #200;
            wstrobe_o = 1'h0;
            #100;
        end
        // released lines show the inverse of the last value
        if (!hold) begin
            {dmi_o, dq_o} = ~f[9];
            wframe_o = 1'h0;
        end
    endtask : send
endmodule : ddrc_ctrl_model

/* test_ddrc_write_crc_check.sv */
`timescale 1ns/1ns
`include "ddrc_consts.svh"

module test_ddrc_write_crc_check;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int PW = 6; // shortest legal alert pulse
    logic clk_sys_i = 1'h0;
    logic rstn_i = 1'h0;
    logic crc_en = 1'h0;
    logic [1:0] org = 2'h1;
    logic bc4 = 1'h0;
    logic a2 = 1'h0;
    logic dm_en = 1'h0;
    logic dbi_en = 1'h0;
    logic mrs_clr = 1'h0;
    wire wstrobe;
    wire wframe;
    wire [15:0] dq;
    wire [1:0] dmi;
    wire alert_n;
    wire alert_oe;
    wire clr_bit;
    wire status;
    wire done;
    logic [71:0] r = {8'hC3, 64'h0123_4567_89AB_CDEF}; // lower tree raw data
    logic [71:0] u; // upper tree raw data
    int errors = 0;
    int tests_run = 0;

    // 20 MHz system clock
    always #25 clk_sys_i = ~clk_sys_i;

    ddrc_write_crc_check #(.PULSE_CYC(PW)) ddrc_write_crc_check_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wstrobe_i(wstrobe), .wframe_i(wframe),
        .dq_i(dq), .dmi_i(dmi), .crc_en_i(crc_en), .org_i(org), .bc4_i(bc4), .a2_i(a2),
        .dm_en_i(dm_en), .dbi_en_i(dbi_en), .mrs_clr_i(mrs_clr), .alert_n_o(alert_n),
        .alert_oe_o(alert_oe), .crc_clr_bit_o(clr_bit), .crc_status_o(status), .wr_done_o(done));

    ddrc_ctrl_model ddrc_ctrl_model_inst (
        .wstrobe_o(wstrobe), .wframe_o(wframe), .dq_o(dq), .dmi_o(dmi));

    // ------------------------------------------------------------
    // reference model and checks
    // ------------------------------------------------------------
    // serial checksum, first bit d[71], zero start
    function automatic logic [7:0] crc8(input logic [71:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 71; i >= 0; i--) begin
            c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8

    // tree inputs as the device should see them
    function automatic logic [71:0] eff(input logic [71:0] d);
        logic [71:0] e;
        e = d;
        for (int n = 0; n < 9; n++) begin
            if (bc4) e[8*n+4 +: 4] = 4'hF;
        end
        if (bc4 && a2) e[71:64] = {d[71:68], 4'hF};
        if (!dm_en && !dbi_en) e[71:64] = 8'hFF;
        if (org == `DDRC_ORG_X4) e[71:32] = '1;
        return e;
    endfunction : eff

    // frame with checksums, each flipped by a mask
    function automatic ddrc_pkg::ddrc_frame_t mk(input logic [7:0] fl, input logic [7:0] fu);
        ddrc_pkg::ddrc_frame_t f;
        logic [7:0] cl;
        logic [7:0] cu;
        cl = crc8(eff(r)) ^ fl;
        cu = crc8(eff(u)) ^ fu;
        f = '1;
        for (int t = 0; t < 8; t++) begin
            for (int n = 0; n < 8; n++) begin
                f[t][n] = r[8*n+t];
                f[t][n+8] = u[8*n+t];
            end
            f[t][16] = r[64+t];
            f[t][17] = u[64+t];
            if (bc4 && a2 && t < 4) begin
                f[t][16] = r[68+t];
                f[t][17] = u[68+t];
            end
            if (bc4 && t > 3) f[t] = '1;
        end
        f[8][15:0] = {cu, cl};
        if (org == `DDRC_ORG_X4) f[9][3:0] = cl[7:4];
        return f;
    endfunction : mk

    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_num(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_num

    // count frame ends and alert cycles, bounded
    task automatic watch(input int k, output int dn, output int al, output int lat);
        int idle;
        int since;
        dn = 0;
        al = 0;
        lat = -1;
        idle = 0;
        since = 0;
        for (int c = 0; c < 90 * k + 40 && idle < 14; c++) begin
            @(negedge clk_sys_i);
            since++;
            if (alert_oe === 1'h1) begin
                if (al == 0) lat = since;
                al++;
                chk_bit("alert_n_o", 1'h0, alert_n);
            end
            if (done === 1'h1) begin
                dn++;
                since = 0;
            end
            if (dn == k) idle++;
        end
    endtask : watch

    // send one frame, or a good one then this one back to back
    task automatic run(input logic [7:0] fl, input logic [7:0] fu, input logic two,
                       output int dn, output int al, output int lat);
        fork
            begin
                if (two) ddrc_ctrl_model_inst.send(mk(8'h00, 8'h00), 1'h1);
                ddrc_ctrl_model_inst.send(mk(fl, fu), 1'h0);
            end
            watch(two ? 2 : 1, dn, al, lat);
        join
    endtask : run

    // one test case: set mode, send, check; after an error also retry and clear
    task automatic tcase(input logic [1:0] o, input logic b, input logic a, input logic [1:0] m,
                         input logic en, input logic [7:0] fl, input logic [7:0] fu,
                         input logic two);
        int dn;
        int al;
        int lat;
        logic err;
        @(negedge clk_sys_i);
        {org, bc4, a2, dbi_en, dm_en, crc_en} = {o, b, a, m, en};
        r = {r[70:0], r[71]} ^ 72'h5A;
        u = ~{r[35:0], r[71:36]};
        err = en && (fl != 8'h00 || fu != 8'h00);
        run(fl, fu, two, dn, al, lat);
        if (en) chk_num("wr_done_o count", two ? 2 : 1, dn);
        chk_num("alert cycles", err ? PW : 0, al);
        if (err) chk_num("alert latency", 1, lat);
        chk_bit("crc_clr_bit_o", err, clr_bit);
        chk_bit("crc_status_o", err, status);
        if (err) begin
            run(8'h00, 8'h00, 1'h0, dn, al, lat);
            chk_num("retry alert cycles", 0, al);
            chk_bit("crc_clr_bit_o held", 1'h1, clr_bit);
            @(negedge clk_sys_i);
            mrs_clr = 1'h1;
            @(negedge clk_sys_i);
            mrs_clr = 1'h0;
            @(negedge clk_sys_i);
            chk_bit("crc_clr_bit_o cleared", 1'h0, clr_bit);
            chk_bit("crc_status_o cleared", 1'h0, status);
        end
    endtask : tcase

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // sequence: org, bc4, a2, {dbi,dm}, enable, flips, back to back
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rstn_i = 1'h1;
        repeat (4) @(negedge clk_sys_i);
        tcase(`DDRC_ORG_X8, 1'h0, 1'h0, 2'h1, 1'h1, 8'h00, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h0, 1'h0, 2'h1, 1'h1, 8'h01, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h0, 1'h0, 2'h0, 1'h1, 8'h00, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h0, 1'h0, 2'h2, 1'h1, 8'h80, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X16, 1'h0, 1'h0, 2'h2, 1'h1, 8'h00, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X16, 1'h0, 1'h0, 2'h1, 1'h1, 8'h00, 8'h04, 1'h0);
        tcase(`DDRC_ORG_X16, 1'h0, 1'h0, 2'h0, 1'h1, 8'h20, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X4, 1'h1, 1'h0, 2'h0, 1'h1, 8'h00, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X4, 1'h1, 1'h1, 2'h0, 1'h1, 8'h10, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h1, 1'h0, 2'h1, 1'h1, 8'h00, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h1, 1'h1, 2'h1, 1'h1, 8'h02, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h1, 1'h1, 2'h0, 1'h1, 8'h00, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X4, 1'h0, 1'h0, 2'h0, 1'h1, 8'h00, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h0, 1'h0, 2'h1, 1'h0, 8'hFF, 8'h00, 1'h0);
        tcase(`DDRC_ORG_X8, 1'h0, 1'h0, 2'h1, 1'h1, 8'h08, 8'h00, 1'h1);
        report_and_stop();
    end

    // watchdog: far beyond the expected run length
    initial begin
        #2000000;
        errors++;
        $display("mismatch watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule : test_ddrc_write_crc_check
